// ===== sdram_bank_burst_access.sv
// quad-bank synchronous dram core: bank rows, bursts, auto precharge
`timescale 1ns/1ps
`include "sdram_core_map.svh"
// Operation
// - every input, command, address and write data is sampled only on the rising clock edge; here rstn_i acts at once when it falls.
// - a bank must be activated before reads or writes to it, and an access only starts on a read or write to an open bank.
// - an activate takes the bank from the two bank inputs and the row from the twelve address inputs.
// - a read or write takes its first burst column from the address captured with it.
// - a burst runs for the programmed length in the programmed order with columns made internally.
// - burst length is one, two, four, eight or a whole page, and a burst terminate ends it early.
// - auto precharge closes the row by itself when its burst ends.
// - a new column can be given every cycle, also in the middle of a burst.
// - one bank can precharge while another bank is accessed.
// - each of four banks is 4096 rows by 256 columns of 32-bit words.
// - the vehicle grade has no self refresh, so its controller refreshes by command only.
// - the precharge flag line picks auto precharge on reads and writes, and all banks on a precharge.
// - chip select high masks commands while running bursts and byte masks go on.
module sdram_bank_burst_access
  import sdram_core_pkg::*;
#(
  parameter int BANK_BITS = `BANK_BITS,
  parameter int ROW_BITS = `ROW_BITS,
  parameter int COL_BITS = `COL_BITS,
  parameter int DATA_BITS = `DATA_BITS
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [BANK_BITS-1:0] ba_i,
  input wire logic [ROW_BITS-1:0] addr_i,
  input wire logic [DATA_BITS/8-1:0] dqm_i,
  input wire logic [DATA_BITS-1:0] dq_i,
  input wire logic [2:0] burst_length_i,
  input wire logic burst_interleave_i,
  input wire logic vehicle_grade_option_i,
  output logic [DATA_BITS-1:0] dq_o,
  output logic [DATA_BITS/8-1:0] dq_oe_n_o,
  output logic self_refresh_o
);
  localparam int NBANKS = 1 << BANK_BITS;
  localparam int NBYTES = DATA_BITS / 8;
  localparam int AW = BANK_BITS + ROW_BITS + COL_BITS;
  localparam logic [3:0] TRP_LAST = 4'(`TRP_CYC - 1);

  logic rst_meta;
  logic rst_n;
  logic grade_taken;
  logic grade;
  cmd_e cmd;
  bank_e bank_state [NBANKS];
  logic [ROW_BITS-1:0] bank_row [NBANKS];
  logic [3:0] pre_cnt [NBANKS];
  logic [DATA_BITS-1:0] mem [0:(1<<AW)-1];
  logic ap_flag;
  logic act_ok;
  logic rw_ok;
  logic rw_write;
  logic single;
  logic pre_hit;
  logic seq_active;
  logic seq_last;
  logic seq_go;
  logic [COL_BITS-1:0] seq_col;
  logic [BANK_BITS-1:0] cur_bank;
  logic cur_ap;
  logic cur_wr;
  logic [NBANKS-1:0] ap_close;
  logic acc_valid;
  logic acc_wr;
  logic [BANK_BITS-1:0] acc_bank;
  logic [COL_BITS-1:0] acc_col;
  logic [AW-1:0] acc_idx;
  logic [NBYTES-1:0] dqm_q;
  logic all_idle;
  logic any_active;

  // reset released through two flops so every register leaves reset together
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // grade strap caught once, on the first edge after release
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      grade_taken <= 1'b0;
      grade <= 1'b0;
    end else if (!grade_taken) begin
      grade_taken <= 1'b1;
      grade <= vehicle_grade_option_i;
    end
  end

  // command decode; self refresh masks everything as well
  always_comb begin
    cmd = decode_cmd({cs_n_i, ras_n_i, cas_n_i, we_n_i});
    if (self_refresh_o) cmd = CMD_NOP;
  end

  assign ap_flag = addr_i[`PRECHARGE_FLAG_POS];
  assign single = (burst_length_i == `LEN_1);
  assign rw_write = (cmd == CMD_WRITE);
  assign act_ok = (cmd == CMD_ACT) && (bank_state[ba_i] == BANK_IDLE);
  assign rw_ok = (cmd == CMD_READ || cmd == CMD_WRITE) && (bank_state[ba_i] == BANK_ACTIVE);
  assign pre_hit = (cmd == CMD_PRE) && seq_active && (ap_flag || ba_i == cur_bank);
  // a running burst gives up its slot to a new column, a terminate or a precharge of its own bank or of all banks
  assign seq_go = seq_active && !rw_ok && (cmd != CMD_BST) && !pre_hit;

  sdram_burst_seq #(
    .COL_BITS(COL_BITS)
  ) sdram_burst_seq_inst (
    .core_clk_i(core_clk_i),
    .rstn_i(rst_n),
    .start_i(rw_ok),
    .stop_i((cmd == CMD_BST) || pre_hit),
    .start_col_i(addr_i[COL_BITS-1:0]),
    .len_code_i(burst_length_i),
    .interleave_i(burst_interleave_i),
    .active_o(seq_active),
    .col_o(seq_col),
    .last_o(seq_last)
  );

  // access of this cycle: a new command wins over the running burst
  always_comb begin
    acc_valid = rw_ok || seq_go;
    acc_bank = rw_ok ? ba_i : cur_bank;
    acc_col = rw_ok ? addr_i[COL_BITS-1:0] : seq_col;
    acc_wr = rw_ok ? rw_write : cur_wr;
    acc_idx = {acc_bank, bank_row[acc_bank], acc_col};
  end

  // banks whose auto precharge begins now: end of burst, early end, or one-word access
  always_comb begin
    ap_close = '0;
    if (rw_ok && ap_flag && single) ap_close[ba_i] = 1'b1;
    if (seq_active && cur_ap && (seq_last || rw_ok || cmd == CMD_BST || pre_hit)) ap_close[cur_bank] = 1'b1;
  end

  // owner of the running burst
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur_bank <= '0;
      cur_ap <= 1'b0;
      cur_wr <= 1'b0;
    end else if (rw_ok) begin
      cur_bank <= ba_i;
      cur_ap <= ap_flag && !single;
      cur_wr <= rw_write;
    end
  end

  // per-bank row state; each bank times its own precharge so others keep working
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < NBANKS; b++) begin
        bank_state[b] <= BANK_IDLE;
        bank_row[b] <= '0;
        pre_cnt[b] <= 4'h0;
      end
    end else begin
      for (int b = 0; b < NBANKS; b++) begin
        if (act_ok && ba_i == BANK_BITS'(b)) begin
          bank_state[b] <= BANK_ACTIVE;
          bank_row[b] <= addr_i;
        end else if (bank_state[b] == BANK_ACTIVE &&
                     (ap_close[b] || (cmd == CMD_PRE && (ap_flag || ba_i == BANK_BITS'(b))))) begin
          bank_state[b] <= BANK_PRECHARGE;
          pre_cnt[b] <= TRP_LAST;
        end else if (bank_state[b] == BANK_PRECHARGE) begin
          if (pre_cnt[b] == 4'h0) bank_state[b] <= BANK_IDLE;
          else pre_cnt[b] <= pre_cnt[b] - 4'h1;
        end
      end
    end
  end

  // array write with byte masks; the array itself has no reset
  always_ff @(posedge core_clk_i) begin
    if (acc_valid && acc_wr) begin
      for (int k = 0; k < NBYTES; k++) begin
        if (!dqm_i[k]) mem[acc_idx][k*8 +: 8] <= dq_i[k*8 +: 8];
      end
    end
  end

  // read data one edge after its column; byte masks act two edges late on reads
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dq_o <= '0;
      dq_oe_n_o <= '1;
      dqm_q <= '0;
    end else begin
      dqm_q <= dqm_i;
      dq_oe_n_o <= (acc_valid && !acc_wr) ? dqm_q : '1;
      if (acc_valid && !acc_wr) dq_o <= mem[acc_idx];
    end
  end

  always_comb begin
    all_idle = 1'b1;
    any_active = 1'b0;
    for (int b = 0; b < NBANKS; b++) begin
      if (bank_state[b] != BANK_IDLE) all_idle = 1'b0;
      if (bank_state[b] == BANK_ACTIVE) any_active = 1'b1;
    end
  end

  // self refresh: entered by refresh with clock enable low, refused on the vehicle grade
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      self_refresh_o <= 1'b0;
    end else if (self_refresh_o) begin
      if (cke_i) self_refresh_o <= 1'b0;
    end else if (cmd == CMD_REF && !cke_i && all_idle && !grade) begin
      self_refresh_o <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_start4;
    rw_ok && burst_length_i == `LEN_4;
  endsequence
  sequence s_quiet3;
    (cmd == CMD_NOP)[*3];
  endsequence

  a_act_opens_row: assert property (act_ok |=> bank_row[$past(ba_i)] == $past(addr_i) && any_active)
    else $error("activate did not open the addressed row");
  a_closed_no_read: assert property ((cmd == CMD_READ && bank_state[ba_i] != BANK_ACTIVE && !seq_active)
    |=> dq_oe_n_o == '1)
    else $error("read to a closed bank drove data");
  a_read_mask_lat: assert property ((rw_ok && !rw_write) |=> dq_oe_n_o == $past(dqm_q))
    else $error("read output enable does not follow byte mask");
  a_burst4_length: assert property (s_start4 ##1 s_quiet3 |=> !seq_active)
    else $error("four-word burst ran the wrong length");
  a_burst4_runs: assert property (s_start4 |=> seq_active)
    else $error("four-word burst did not continue");
  a_burst_stop: assert property ((seq_active && cmd == CMD_BST) |=> !seq_active)
    else $error("burst terminate did not end the burst");
  a_auto_pre: assert property ((seq_last && cur_ap) |=> bank_state[$past(cur_bank)] == BANK_PRECHARGE)
    else $error("auto precharge did not start at burst end");
  a_random_col: assert property ((seq_active && rw_ok) |-> acc_valid && acc_col == addr_i[COL_BITS-1:0])
    else $error("new column not taken during a burst");
  a_pre_all: assert property ((cmd == CMD_PRE && ap_flag) |=> !any_active)
    else $error("precharge all left a bank open");
  a_inhibit_burst: assert property ((cs_n_i && seq_active && !seq_last) |=> seq_active)
    else $error("deselect stopped a running burst");
  a_grade_no_sr: assert property (grade_taken && grade |-> !self_refresh_o)
    else $error("self refresh entered on the vehicle grade");
endmodule : sdram_bank_burst_access

// ===== sdram_bank_burst_access_tb_top.sv
// self-checking bench for the quad-bank burst core
`timescale 1ns/1ps
`include "sdram_core_map.svh"
`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end
module sdram_bank_burst_access_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic grade = 1'b0;
  logic [2:0] blen = 3'h0;
  logic il = 1'b0;
  logic cke;
  logic [3:0] cmd;
  logic [3:0] dqm;
  logic [3:0] oe_n;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic self_ref;
  int miscompares = 0;
  int n_compared = 0;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  sdram_ctl_model sdram_ctl_model_inst (.core_clk_i(core_clk), .cke_o(cke), .cmd_o(cmd), .ba_o(ba),
    .addr_o(addr), .wdata_o(wdata), .dqm_o(dqm));
  sdram_bank_burst_access sdram_bank_burst_access_inst (.core_clk_i(core_clk), .rstn_i(rstn), .cke_i(cke),
    .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i(ba), .addr_i(addr),
    .dqm_i(dqm), .dq_i(wdata), .burst_length_i(blen), .burst_interleave_i(il),
    .vehicle_grade_option_i(grade), .dq_o(rdata), .dq_oe_n_o(oe_n), .self_refresh_o(self_ref));
  // word stored at each place, unique per bank, row and column
  function automatic logic [31:0] pat(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c);
    return {b, r, ~c, 2'b10, c};
  endfunction : pat
  task automatic nop();
    sdram_ctl_model_inst.issue(4'h7, 2'h0, 12'h000, 32'h0, 4'h0);
  endtask : nop
  task automatic acc(input logic [3:0] c, input logic [1:0] b, input logic [11:0] r, input logic [7:0] col,
                     input logic ap);
    sdram_ctl_model_inst.access(c, b, r, col, ap, pat(b, r, col));
  endtask : acc
  // the column read at the last edge is driven now (latency one), then one cycle on
  task automatic see(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c);
    `CHK("read word", pat(b, r, c), rdata)
    `CHK("read enable", 4'h0, oe_n)
    nop();
  endtask : see
  // strap is caught after release, so it is set while reset is held
  task automatic do_reset(input logic g);
    rstn = 1'b0;
    grade = g;
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask : do_reset
  task automatic burst(input logic [2:0] code, input int n, input logic [7:0] st, input logic ilv);
    logic [7:0] m;
    m = 8'(n - 1);
    blen = code;
    il = ilv;
    acc(`CODE_READ, 2'h1, 12'habc, st, 1'b0);
    for (int i = 0; i < n; i++) see(2'h1, 12'habc, (st & ~m) | ((ilv ? (st ^ 8'(i)) : (st + 8'(i))) & m));
    `CHK("burst end", 4'hf, oe_n)
  endtask : burst
  // back-to-back single writes, then lengths one to eight, both orders at four and eight, from mid-window starts
  task automatic s_bursts();
    blen = `LEN_1;
    for (int c = 0; c < 8; c++) acc(`CODE_WRITE, 2'h1, 12'habc, 8'(c), 1'b0);
    acc(`CODE_WRITE, 2'h1, 12'habc, 8'hfe, 1'b0);
    acc(`CODE_WRITE, 2'h1, 12'habc, 8'hff, 1'b0);
    burst(`LEN_1, 1, 8'h2, 1'b0);
    burst(`LEN_2, 2, 8'h7, 1'b0);
    burst(`LEN_4, 4, 8'h5, 1'b0);
    burst(`LEN_4, 4, 8'h5, 1'b1);
    burst(`LEN_8, 8, 8'h3, 1'b0);
    burst(`LEN_8, 8, 8'h6, 1'b1);
  endtask : s_bursts
  // whole page wraps past the last column until a terminate cuts it
  task automatic s_page_stop();
    blen = `LEN_FULL;
    il = 1'b0;
    acc(`CODE_READ, 2'h1, 12'habc, 8'hfe, 1'b0);
    see(2'h1, 12'habc, 8'hfe);
    see(2'h1, 12'habc, 8'hff);
    sdram_ctl_model_inst.issue(`CODE_BST, 2'h1, 12'h000, 32'h0, 4'h0);
    `CHK("page wrap", pat(2'h1, 12'habc, 8'h00), rdata)
    nop();
    `CHK("terminated", 4'hf, oe_n)
  endtask : s_page_stop
  // a new column every cycle cuts the running burst
  task automatic s_random();
    blen = `LEN_4;
    acc(`CODE_READ, 2'h1, 12'habc, 8'h06, 1'b0);
    `CHK("random col", pat(2'h1, 12'habc, 8'h06), rdata)
    acc(`CODE_READ, 2'h1, 12'habc, 8'h01, 1'b0);
    `CHK("random col", pat(2'h1, 12'habc, 8'h01), rdata)
    acc(`CODE_READ, 2'h1, 12'habc, 8'h03, 1'b0);
    see(2'h1, 12'habc, 8'h03);
    see(2'h1, 12'habc, 8'h00);
  endtask : s_random
  // a deselected read is ignored, the burst runs on, and its byte mask still acts two edges later
  task automatic s_deselect();
    blen = `LEN_8;
    acc(`CODE_READ, 2'h1, 12'habc, 8'h00, 1'b0);
    sdram_ctl_model_inst.issue(4'hd, 2'h1, 12'h007, 32'h0, 4'h2);
    see(2'h1, 12'habc, 8'h01);
    `CHK("mask", 4'h2, oe_n)
    `CHK("deselected", pat(2'h1, 12'habc, 8'h02), rdata)
    sdram_ctl_model_inst.issue(`CODE_BST, 2'h1, 12'h000, 32'h0, 4'h0);
  endtask : s_deselect
  // a new row opens only if auto precharge or precharge-all really closed the old one
  task automatic s_precharge();
    blen = `LEN_1;
    acc(`CODE_WRITE, 2'h2, 12'h001, 8'h09, 1'b1);
    acc(`CODE_READ, 2'h1, 12'habc, 8'h02, 1'b0);
    see(2'h1, 12'habc, 8'h02);
    // a two-word burst with auto precharge must close its row at the end of the burst
    blen = `LEN_2;
    acc(`CODE_WRITE, 2'h2, 12'h002, 8'h09, 1'b1);
    blen = `LEN_1;
    acc(`CODE_WRITE, 2'h0, 12'h005, 8'h00, 1'b0);
    acc(`CODE_WRITE, 2'h3, 12'h005, 8'h00, 1'b0);
    sdram_ctl_model_inst.issue(`CODE_PRE, 2'h0, 12'h400, 32'h0, 4'h0);
    acc(`CODE_WRITE, 2'h3, 12'h006, 8'h00, 1'b0);
    acc(`CODE_READ, 2'h2, 12'h001, 8'h09, 1'b1);
    see(2'h2, 12'h001, 8'h09);
    acc(`CODE_READ, 2'h3, 12'h005, 8'h00, 1'b0);
    see(2'h3, 12'h005, 8'h00);
  endtask : s_precharge
  // self refresh follows the clock enable, and is refused on the vehicle grade
  task automatic s_selfref();
    sdram_ctl_model_inst.issue(`CODE_PRE, 2'h0, 12'h400, 32'h0, 4'h0);
    // a read to a closed bank is refused silently
    sdram_ctl_model_inst.issue(`CODE_READ, 2'h0, 12'h000, 32'h0, 4'h0);
    `CHK("refused read", 4'hf, oe_n)
    sdram_ctl_model_inst.self_refresh(1'b1);
    `CHK("self refresh on", 1'b1, self_ref)
    sdram_ctl_model_inst.self_refresh(1'b0);
    `CHK("self refresh off", 1'b0, self_ref)
    do_reset(1'b1);
    sdram_ctl_model_inst.self_refresh(1'b1);
    `CHK("vehicle grade", 1'b0, self_ref)
    sdram_ctl_model_inst.self_refresh(1'b0);
  endtask : s_selfref
  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    do_reset(1'b0);
    s_bursts();
    s_page_stop();
    s_random();
    s_deselect();
    s_precharge();
    s_selfref();
    complete_run();
  end
  // the tests take just over a hundred cycles, so this only fires on a hang
  initial begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end
endmodule : sdram_bank_burst_access_tb_top

// ===== sdram_burst_seq.sv
// column sequencer that walks one burst after its first column
`timescale 1ns/1ps
`include "sdram_core_map.svh"
module sdram_burst_seq
  import sdram_core_pkg::*;
#(
  parameter int COL_BITS = `COL_BITS
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [COL_BITS-1:0] start_col_i,
  input wire logic [2:0] len_code_i,
  input wire logic interleave_i,
  output logic active_o,
  output logic [COL_BITS-1:0] col_o,
  output logic last_o
);
  logic [COL_BITS-1:0] base;
  logic [COL_BITS-1:0] cnt;
  logic [15:0] mask;
  logic [15:0] next_mask;
  logic full;
  logic ilv;
  logic [15:0] col_wide;

  assign next_mask = len_mask(len_code_i, COL_BITS);
  // a whole-page burst wraps forever and ends only by stop or a new command
  assign last_o = active_o && !full && (cnt == mask[COL_BITS-1:0]);
  assign col_wide = burst_col(16'(base), 16'(cnt), mask, ilv);
  assign col_o = col_wide[COL_BITS-1:0];

  // length and order latched at start so a change mid-burst is harmless
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_o <= 1'b0;
      base <= '0;
      cnt <= '0;
      mask <= 16'h0000;
      full <= 1'b0;
      ilv <= 1'b0;
    end else if (start_i) begin
      active_o <= (next_mask != 16'h0000);
      base <= start_col_i;
      cnt <= COL_BITS'(1);
      mask <= next_mask;
      full <= (len_code_i == `LEN_FULL);
      ilv <= interleave_i && (len_code_i != `LEN_FULL); // page bursts are linear only
    end else if (stop_i || last_o) begin
      active_o <= 1'b0;
    end else if (active_o) begin
      cnt <= cnt + COL_BITS'(1);
    end
  end
endmodule : sdram_burst_seq

// ===== sdram_core_map.svh
// constants for the sdram bank and burst core
`ifndef SDRAM_CORE_MAP_SVH
`define SDRAM_CORE_MAP_SVH

// array geometry
`define BANK_BITS 2
`define ROW_BITS 12
`define COL_BITS 8
`define DATA_BITS 32

// command codes as {cs_n, ras_n, cas_n, we_n}
`define CODE_LMR 4'h0
`define CODE_REF 4'h1
`define CODE_PRE 4'h2
`define CODE_ACT 4'h3
`define CODE_WRITE 4'h4
`define CODE_READ 4'h5
`define CODE_BST 4'h6

// address line that carries auto precharge / all-bank select
`define PRECHARGE_FLAG_POS 10

// burst length codes
`define LEN_1 3'h0
`define LEN_2 3'h1
`define LEN_4 3'h2
`define LEN_8 3'h3
`define LEN_FULL 3'h7

// precharge time, rounded up to whole cycles
`define CLK_MHZ 25
`define TRP_NS 20
`define TRP_CYC ((`TRP_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== sdram_core_pkg.sv
// types and helper functions for the sdram bank and burst core
package sdram_core_pkg;
  `include "sdram_core_map.svh"

  typedef enum {CMD_NOP, CMD_LMR, CMD_REF, CMD_PRE, CMD_ACT, CMD_WRITE, CMD_READ, CMD_BST} cmd_e;
  typedef enum {BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGE} bank_e;

  // chip select high masks every command
  function automatic cmd_e decode_cmd(input logic [3:0] code);
    cmd_e c;
    c = CMD_NOP;
    if (code == `CODE_LMR) c = CMD_LMR;
    else if (code == `CODE_REF) c = CMD_REF;
    else if (code == `CODE_PRE) c = CMD_PRE;
    else if (code == `CODE_ACT) c = CMD_ACT;
    else if (code == `CODE_WRITE) c = CMD_WRITE;
    else if (code == `CODE_READ) c = CMD_READ;
    else if (code == `CODE_BST) c = CMD_BST;
    return c;
  endfunction : decode_cmd

  // wrap mask of a burst: length minus one, whole page for full
  function automatic logic [15:0] len_mask(input logic [2:0] code, input int col_bits);
    logic [15:0] m;
    m = 16'h0000;
    if (code == `LEN_2) m = 16'h0001;
    else if (code == `LEN_4) m = 16'h0003;
    else if (code == `LEN_8) m = 16'h0007;
    else if (code == `LEN_FULL) m = 16'((32'h1 << col_bits) - 32'h1);
    return m;
  endfunction : len_mask

  // column of step cnt within the wrap window around base
  function automatic logic [15:0] burst_col(input logic [15:0] base, input logic [15:0] cnt,
                                            input logic [15:0] mask, input logic interleave);
    logic [15:0] low;
    low = interleave ? (base ^ cnt) : 16'(base + cnt);
    return (base & ~mask) | (low & mask);
  endfunction : burst_col
endpackage : sdram_core_pkg

// ===== sdram_ctl_model.sv
// controller model driving commands, addresses and write data
`timescale 1ns/1ps
`include "sdram_core_map.svh"
module sdram_ctl_model (
  input wire logic core_clk_i,
  output logic cke_o,
  output logic [3:0] cmd_o,
  output logic [1:0] ba_o,
  output logic [11:0] addr_o,
  output logic [31:0] wdata_o,
  output logic [3:0] dqm_o
);
  logic [3:0] open_q;
  logic [11:0] row_q [4];
  // idle pins at time zero: no command, clock enabled
  initial begin
    cke_o = 1'b1;
    cmd_o = 4'h7;
    ba_o = 2'h0;
    addr_o = 12'h000;
    wdata_o = 32'h0000_0000;
    dqm_o = 4'h0;
    open_q = 4'h0;
  end
  // one command a cycle, set after a falling edge and held over the next rising edge
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] m);
    cmd_o = c;
    ba_o = b;
    addr_o = a;
    wdata_o = (c == `CODE_WRITE) ? d : ~wdata_o; // released data lines never keep the last word
    dqm_o = m;
    if (c == `CODE_ACT) open_q[b] = 1'b1;
    if (c == `CODE_PRE && a[10]) open_q = 4'h0;
    if (c == `CODE_PRE || ((c == `CODE_READ || c == `CODE_WRITE) && a[10])) open_q[b] = 1'b0;
    @(negedge core_clk_i);
  endtask : issue
  // reach a row the legal way: close another row, let precharge finish, then activate
  task automatic access(input logic [3:0] c, input logic [1:0] b, input logic [11:0] r, input logic [7:0] col,
                        input logic ap, input logic [31:0] d);
    if (open_q[b] && row_q[b] != r) issue(`CODE_PRE, b, 12'h000, 32'h0, 4'h0);
    if (!open_q[b]) begin
      issue(4'h7, b, 12'h000, 32'h0, 4'h0);
      issue(4'h7, b, 12'h000, 32'h0, 4'h0);
      issue(`CODE_ACT, b, r, 32'h0, 4'h0);
      row_q[b] = r;
    end
    issue(c, b, {1'b0, ap, 2'b00, col}, d, 4'h0);
  endtask : access
  // enter or leave self refresh; a vehicle-grade controller refreshes by command instead
  task automatic self_refresh(input logic on);
    cke_o = !on;
    issue(on ? `CODE_REF : 4'h7, 2'h0, 12'h000, 32'h0, 4'h0);
  endtask : self_refresh
endmodule : sdram_ctl_model
